//--- pkg/isc_regs.vh
`ifndef ISC_REGS_VH
`define ISC_REGS_VH
// register byte addresses
`define ISC_ADDR_STD_HIGH   32'h50001314
`define ISC_ADDR_STD_LOW    32'h50001318
`define ISC_ADDR_FAST_HIGH  32'h5000131C
`define ISC_ADDR_FAST_LOW   32'h50001320
// reset values
`define ISC_RST_STD_HIGH    16'h0048
`define ISC_RST_STD_LOW     16'h004F
`define ISC_RST_FAST_HIGH   16'h0008
`define ISC_RST_FAST_LOW    16'h0017
// minimum stored counts
`define ISC_MIN_HIGH        16'h0006
`define ISC_MIN_LOW         16'h0008
// idle threshold offset over the standard high count
`define ISC_IDLE_OFFSET     16'h000A
// speed select encodings
`define ISC_SPEED_STD       2'h1
`define ISC_SPEED_FAST      2'h2
`define ISC_SPEED_HIGH      2'h3
`endif

//--- verilog/isc_phase_counter.v
`timescale 1ns/10ps
`default_nettype none
module isc_phase_counter #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             run,
  input  wire [WIDTH-1:0] high_count,
  input  wire [WIDTH-1:0] low_count,
  output reg              clock_level,
  output reg              phase_done
);
  reg  [WIDTH-1:0] count;
  wire [WIDTH-1:0] limit;

  assign limit = clock_level ? high_count : low_count;

  // ----------------------------------------
  // phase timing: each phase lasts its count in cycles
  // ----------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count       <= 16'h0000;
      clock_level <= 1'b1;
      phase_done  <= 1'b0;
    end
    else if (!run)
    begin
      count       <= 16'h0000;
      clock_level <= 1'b1;
      phase_done  <= 1'b0;
    end
    else if (count >= limit - 16'h0001)
    begin
      count       <= 16'h0000;
      clock_level <= ~clock_level;
      phase_done  <= 1'b1;
    end
    else
    begin
      count      <= count + 16'h0001;
      phase_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verilog/isc_clock_counts.v
// Summary of operation
// - standard high count sets serial clock high cycles in standard speed
// - standard low count sets serial clock low cycles in standard speed
// - fast high count times clock high phase in fast speed
// - fast low count times clock low phase in fast speed
// - high-speed mode uses fast counts for master code, start byte, general call
// - count registers write only while controller disabled; otherwise unchanged
// - low count writes below 8 store 8
// - 16-bit counter flags bus idle at standard high count plus 10
`timescale 1ns/10ps
`default_nettype none
`include "isc_regs.vh"
module isc_clock_counts #(
  parameter WIDTH = 16
) (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        CONTROLLER_ENABLE,
  input  wire [1:0]  SPEED_SELECT,
  input  wire        HS_PREAMBLE,
  input  wire        BUS_ACTIVITY,
  output reg         SERIAL_CLOCK,
  output reg         PHASE_DONE,
  output reg         BUS_IDLE
);
  reg  [WIDTH-1:0] std_high_count_field;
  reg  [WIDTH-1:0] std_low_count_field;
  reg  [WIDTH-1:0] fast_high_count_field;
  reg  [WIDTH-1:0] fast_low_count_field;
  reg  [WIDTH-1:0] idle_count;
  reg  [WIDTH-1:0] next_rdata;
  reg              next_err;
  reg              en_meta;
  reg              en_sync;
  reg              act_meta;
  reg              act_sync;
  wire             wr;
  wire             wr_ok;
  wire [WIDTH-1:0] wdata;
  wire [WIDTH-1:0] high_min;
  wire [WIDTH-1:0] low_min;
  wire             use_fast;
  wire [WIDTH-1:0] sel_high;
  wire [WIDTH-1:0] sel_low;
  wire [WIDTH-1:0] idle_limit;
  wire             ph_level;
  wire             ph_done;
  wire             wr_std_high;
  wire             wr_std_low;
  wire             wr_fast_high;
  wire             wr_fast_low;
  reg  [WIDTH-1:0] next_idle_count;
  reg              next_bus_idle;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      en_meta  <= 1'b0;
      en_sync  <= 1'b0;
      act_meta <= 1'b0;
      act_sync <= 1'b0;
    end
    else
    begin
      en_meta  <= CONTROLLER_ENABLE;
      en_sync  <= en_meta;
      act_meta <= BUS_ACTIVITY;
      act_sync <= act_meta;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr       = PSEL & PENABLE & PWRITE;
  assign wr_ok    = wr & ~en_sync;
  assign wdata    = PWDATA[WIDTH-1:0];
  assign high_min = (wdata < `ISC_MIN_HIGH) ? `ISC_MIN_HIGH : wdata;
  assign low_min  = (wdata < `ISC_MIN_LOW) ? `ISC_MIN_LOW : wdata;

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      std_high_count_field  <= `ISC_RST_STD_HIGH;
      std_low_count_field   <= `ISC_RST_STD_LOW;
      fast_high_count_field <= `ISC_RST_FAST_HIGH;
      fast_low_count_field  <= `ISC_RST_FAST_LOW;
    end
    else
    begin
      if (wr_std_high)
        std_high_count_field  <= high_min;
      if (wr_std_low)
        std_low_count_field   <= low_min;
      if (wr_fast_high)
        fast_high_count_field <= high_min;
      if (wr_fast_low)
        fast_low_count_field  <= low_min;
    end
  end

  // ----------------------------------------
  // write strobes, one per count register
  // ----------------------------------------
  assign wr_std_high  = wr_ok & (PADDR == `ISC_ADDR_STD_HIGH);
  assign wr_std_low   = wr_ok & (PADDR == `ISC_ADDR_STD_LOW);
  assign wr_fast_high = wr_ok & (PADDR == `ISC_ADDR_FAST_HIGH);
  assign wr_fast_low  = wr_ok & (PADDR == `ISC_ADDR_FAST_LOW);

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @*
  begin
    next_rdata = 16'h0000;
    next_err   = 1'b0;
    case (PADDR)
      `ISC_ADDR_STD_HIGH:  next_rdata = std_high_count_field;
      `ISC_ADDR_STD_LOW:   next_rdata = std_low_count_field;
      `ISC_ADDR_FAST_HIGH: next_rdata = fast_high_count_field;
      `ISC_ADDR_FAST_LOW:  next_rdata = fast_low_count_field;
      default:             next_err   = 1'b1;
    endcase
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & next_err;
      if (PSEL & ~PENABLE & ~PWRITE)
        PRDATA <= {16'h0000, next_rdata};
      else
        PRDATA <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // speed selection and clock phases
  // ----------------------------------------
  assign use_fast = (SPEED_SELECT == `ISC_SPEED_FAST) |
                    ((SPEED_SELECT == `ISC_SPEED_HIGH) & HS_PREAMBLE);
  assign sel_high = use_fast ? fast_high_count_field : std_high_count_field;
  assign sel_low  = use_fast ? fast_low_count_field : std_low_count_field;

  // ----------------------------------------
  // clock phases from the selected counts
  // ----------------------------------------
  isc_phase_counter #(
    .WIDTH (WIDTH)
  ) u_phase (
    .clk         (CLK),
    .resetn      (RESETN),
    .run         (en_sync),
    .high_count  (sel_high),
    .low_count   (sel_low),
    .clock_level (ph_level),
    .phase_done  (ph_done)
  );

  // ----------------------------------------
  // bus idle detection
  // ----------------------------------------
  assign idle_limit = std_high_count_field + `ISC_IDLE_OFFSET;

  always @*
  begin
    next_idle_count = idle_count;
    next_bus_idle   = BUS_IDLE;
    if (act_sync)
    begin
      next_idle_count = 16'h0000;
      next_bus_idle   = 1'b0;
    end
    else if (idle_count >= idle_limit)
      next_bus_idle = 1'b1;
    else
      next_idle_count = idle_count + 16'h0001;
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      idle_count   <= 16'h0000;
      BUS_IDLE     <= 1'b0;
      SERIAL_CLOCK <= 1'b1;
      PHASE_DONE   <= 1'b0;
    end
    else
    begin
      idle_count   <= next_idle_count;
      BUS_IDLE     <= next_bus_idle;
      SERIAL_CLOCK <= ph_level;
      PHASE_DONE   <= ph_done;
    end
  end
endmodule
`default_nettype wire

//--- tb/isc_clock_counts_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "isc_regs.vh"
module isc_chk (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        CONTROLLER_ENABLE,
  input wire logic        BUS_ACTIVITY,
  input wire logic        SERIAL_CLOCK,
  input wire logic        PHASE_DONE,
  input wire logic        BUS_IDLE
);
  // ----
  // checks
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire rd = PREADY && !PWRITE;
  a_high_floor: assert property (
    rd && (PADDR == `ISC_ADDR_STD_HIGH || PADDR == `ISC_ADDR_FAST_HIGH)
    |-> PRDATA[15:0] >= `ISC_MIN_HIGH) else $error("high count below 6");
  a_low_floor: assert property (
    rd && (PADDR == `ISC_ADDR_STD_LOW || PADDR == `ISC_ADDR_FAST_LOW)
    |-> PRDATA[15:0] >= `ISC_MIN_LOW) else $error("low count below 8");
  a_read_upper: assert property (
    rd |-> PRDATA[31:16] == 16'h0000) else $error("upper read bits set");
  a_high_span: assert property (disable iff (!RESETN || !CONTROLLER_ENABLE)
    $rose(SERIAL_CLOCK) |-> SERIAL_CLOCK [*6]) else $error("high phase short");
  a_low_span: assert property (disable iff (!RESETN || !CONTROLLER_ENABLE)
    $fell(SERIAL_CLOCK) |-> !SERIAL_CLOCK [*8]) else $error("low phase short");
  a_gen_stopped: assert property (
    !CONTROLLER_ENABLE [*5] |-> SERIAL_CLOCK && !PHASE_DONE) else $error("clock runs");
  a_idle_quiet: assert property (
    $rose(BUS_IDLE) |-> !$past(BUS_ACTIVITY, 8)) else $error("idle too early");
  a_idle_clear: assert property (
    BUS_ACTIVITY [*5] |-> !BUS_IDLE) else $error("idle during activity");
endmodule
bind isc_clock_counts isc_chk i_isc_chk (.*);
`default_nettype wire

//--- tb/isc_bus_party.sv
`timescale 1ns/10ps
`default_nettype none
module isc_bus_party (
  input  wire logic clk,
  input  wire logic talk,
  output var  logic activity
);
  // ----
  // another bus party holds the bus while talking
  // ----
  initial activity = 1'b0;
  always @(posedge clk) activity <= talk;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "isc_regs.vh"
module tb_top;
  // ----
  // bench
  // ----
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, en = 0, hs = 0, talk = 0;
  logic [31:0] pa = 0, pwd = 0, prd, r;
  logic [1:0]  spd = `ISC_SPEED_STD;
  logic        rdy, err, sck, pd, idle, act, e;
  logic [15:0] rv [4] = '{`ISC_RST_STD_HIGH, `ISC_RST_STD_LOW, `ISC_RST_FAST_HIGH, `ISC_RST_FAST_LOW};
  int          n_errors = 0, tests_run = 0, cyc = 0, h, l, p;
  isc_clock_counts i_isc_clock_counts (.CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .CONTROLLER_ENABLE(en), .SPEED_SELECT(spd), .HS_PREAMBLE(hs), .BUS_ACTIVITY(act),
    .SERIAL_CLOCK(sck), .PHASE_DONE(pd), .BUS_IDLE(idle));
  isc_bus_party i_isc_bus_party (.clk(clk), .talk(talk), .activity(act));
  always #2 clk = ~clk;
  task end_sim;
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim;
    end
  end
  task check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(negedge clk);
    psel = 1; pwr = w; pa = a; pwd = d;
    @(negedge clk);
    pen = 1;
    while (rdy !== 1'b1) @(negedge clk);
    r = prd;
    e = err;
    @(negedge clk);
    psel = 0; pen = 0;
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 32'h50001314 + 4 * i, 0);
      check(r, {16'h0000, rv[i]});
      check(e, 0);
      apb(1, 32'h50001314 + 4 * i, i[0] ? 7 : 5);
      apb(0, 32'h50001314 + 4 * i, 0);
      check(r, i[0] ? 8 : 6);
    end
    apb(0, 32'h50001324, 0);
    check(r, 0);
    check(e, 1);
  endtask
  task t_lock;
    en = 1;
    repeat (4) @(negedge clk);
    apb(1, `ISC_ADDR_STD_LOW, 32'h00001234);
    apb(0, `ISC_ADDR_STD_LOW, 0);
    check(r, 8);
    en = 0;
    repeat (4) @(negedge clk);
  endtask
  task period;
    h = 0; l = 0; p = 0;
    while (sck !== 1'b0) @(negedge clk);
    while (sck !== 1'b1) @(negedge clk);
    while (sck === 1'b1)
    begin
      p = p + (pd === 1'b1);
      @(negedge clk);
      h++;
    end
    while (sck === 1'b0)
    begin
      p = p + (pd === 1'b1);
      @(negedge clk);
      l++;
    end
  endtask
  task t_clock;
    apb(1, `ISC_ADDR_STD_HIGH, 6);
    apb(1, `ISC_ADDR_STD_LOW, 9);
    apb(1, `ISC_ADDR_FAST_HIGH, 7);
    apb(1, `ISC_ADDR_FAST_LOW, 8);
    for (int m = 1; m < 5; m++)
    begin
      spd = (m == 4) ? 2'h3 : m[1:0]; hs = (m == 3); en = 1;
      period;
      check(h, (m == 2 || m == 3) ? 7 : 6);
      check(l, (m == 2 || m == 3) ? 8 : 9);
      check(p, 2);
      en = 0;
      repeat (4) @(negedge clk);
    end
  endtask
  task t_idle;
    talk = 1;
    repeat (6) @(negedge clk);
    check(idle, 0);
    talk = 0; h = 0;
    while (idle !== 1'b1 && h < 100) @(negedge clk) h++;
    check(h >= 16 && h <= 24, 1);
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1;
    t_regs;
    t_lock;
    t_clock;
    t_idle;
    end_sim;
  end
endmodule
`default_nettype wire
